// ===== rtl/dp_ram_steering.sv
`timescale 1ns/1ps
`default_nettype none
`include "dp_steer_cfg.svh"


module dp_ram_steering (
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  input  wire logic                 local_req_valid,
  output logic                      local_req_ready,
  input  wire logic                 local_req_write,
  input  wire logic [`ADDR_W-1:0]   local_req_addr,
  input  wire logic                 local_req_bhe_n,
  input  wire logic [`WORD_W-1:0]   local_req_wdata,
  output logic                      local_done,
  output logic [`WORD_W-1:0]        local_rdata,
  input  wire logic                 bus_mem_rd_n,
  input  wire logic                 bus_mem_wr_n,
  input  wire logic                 board_select,
  input  wire logic [`ADDR_W-1:1]   bus_addr,
  input  wire logic                 buffered_address_bit0,
  input  wire logic                 byte_high_enable_n,
  input  wire logic [`WORD_W-1:0]   bus_data_in,
  output logic [`WORD_W-1:0]        bus_data_out,
  output logic [`WORD_W-1:0]        bus_data_oe,
  output logic                      word_lane_en_n,
  output logic                      swap_lane_en_n,
  output logic                      bus_transfer_direction,
  output logic                      bus_xack_n,
  output logic                      remote_ram_request,
  output logic                      local_grant,
  output logic                      remote_grant,
  output logic [`ADDR_W-1:1]        ram_addr,
  output logic [`WORD_W-1:0]        ram_wdata,
  output logic                      ram_read,
  output logic                      low_byte_write_strobe_n,
  output logic                      high_byte_write_strobe_n,
  input  wire logic [`WORD_W-1:0]   ram_rdata,
  input  wire logic                 ram_ack
);

  // ****************************************
  // local request queue
  // ****************************************
  logic [`LQ_W-1:0]         lq_in;
  logic [`LQ_W-1:0]         lq_out;
  logic                     lq_valid;
  logic                     lq_pop;
  dp_steer_pkg::xfer_mode_e lq_mode;

  assign lq_in = {local_req_write, local_req_bhe_n, local_req_addr, local_req_wdata};
  assign lq_mode = dp_steer_pkg::xfer_mode_e'({lq_out[`LQ_BHE], lq_out[`LQ_A0]});

  req_fifo #(
    .W     (`LQ_W),
    .DEPTH (`LQ_DEPTH)
  ) u_lq (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (local_req_valid),
    .in_ready  (local_req_ready),
    .in_data   (lq_in),
    .out_valid (lq_valid),
    .out_ready (lq_pop),
    .out_data  (lq_out)
  );

  // ****************************************
  // pin synchroniser and remote decode
  // ****************************************
  dp_steer_pkg::steer_state_s st_r;
  dp_steer_pkg::steer_state_s st_nxt;
  logic [`SYNC_W-1:0]       pin_vec;
  logic                     pins_stable;
  logic                     cmd_now;
  logic                     remote_now;
  dp_steer_pkg::xfer_mode_e pin_mode;
  logic [`WORD_W-1:0]       pin_data;

  assign pin_vec = {bus_data_in, bus_addr, byte_high_enable_n, buffered_address_bit0,
                    board_select, bus_mem_wr_n, bus_mem_rd_n};
  // command and address only: undriven data lanes float while reading
  assign pins_stable = (st_r.s2[`SY_ADDR_HI:`SY_RD] == st_r.s3[`SY_ADDR_HI:`SY_RD]);
  assign cmd_now = (!st_r.s3[`SY_RD] || !st_r.s3[`SY_WR]) && st_r.s3[`SY_SEL];
  assign remote_now = pins_stable ? cmd_now : st_r.req;
  assign pin_mode = dp_steer_pkg::xfer_mode_e'({st_r.s3[`SY_BHE], st_r.s3[`SY_A0]});
  assign pin_data = st_r.s3[`SY_DATA_HI:`SY_DATA_LO];

  // ****************************************
  // arbiter and steering
  // ****************************************
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pin_vec;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.req  = remote_now;
    st_nxt.done = 1'b0;
    lq_pop      = 1'b0;
    case (st_r.state)
      dp_steer_pkg::ST_IDLE: begin
        // local checked first, so a same-cycle remote waits
        if (lq_valid) begin
          lq_pop         = 1'b1;
          st_nxt.mode    = lq_mode;
          st_nxt.rd_xfer = !lq_out[`LQ_WR];
          st_nxt.addr    = lq_out[`LQ_ADDR_HI:`LQ_ADDR_LO];
          st_nxt.wdata   = lq_out[`LQ_DATA_HI:`LQ_DATA_LO];
          if (lq_mode == dp_steer_pkg::MODE_NONE) begin
            st_nxt.done = 1'b1;
          end else begin
            st_nxt.state   = dp_steer_pkg::ST_LOCAL;
            st_nxt.rd      = !lq_out[`LQ_WR];
            st_nxt.we_lo_n = !(lq_out[`LQ_WR] && !lq_out[`LQ_A0]);
            st_nxt.we_hi_n = !(lq_out[`LQ_WR] && !lq_out[`LQ_BHE]);
          end
        end else if (pins_stable && cmd_now) begin
          st_nxt.mode    = pin_mode;
          st_nxt.rd_xfer = !st_r.s3[`SY_RD];
          st_nxt.addr    = st_r.s3[`SY_ADDR_HI:`SY_ADDR_LO];
          // odd byte arrives on the low lanes; store it in the upper half
          st_nxt.wdata   = (pin_mode == dp_steer_pkg::MODE_ODD) ?
                           {pin_data[`LANE_LO_MSB:0], pin_data[`LANE_LO_MSB:0]} :
                           pin_data;
          if (pin_mode == dp_steer_pkg::MODE_NONE) begin
            st_nxt.state = dp_steer_pkg::ST_SLAVE_WAIT;
          end else begin
            st_nxt.state   = dp_steer_pkg::ST_SLAVE;
            st_nxt.rd      = !st_r.s3[`SY_RD];
            st_nxt.we_lo_n = !(st_r.s3[`SY_RD] && !st_r.s3[`SY_A0]);
            st_nxt.we_hi_n = !(st_r.s3[`SY_RD] && !st_r.s3[`SY_BHE]);
          end
        end
      end
      dp_steer_pkg::ST_LOCAL: begin
        if (ram_ack) begin
          st_nxt.rd      = 1'b0;
          st_nxt.we_lo_n = 1'b1;
          st_nxt.we_hi_n = 1'b1;
          st_nxt.lrdata  = st_r.rd_xfer ? ram_rdata : st_r.lrdata;
          st_nxt.done    = 1'b1;
          st_nxt.state   = dp_steer_pkg::ST_IDLE;
        end
      end
      dp_steer_pkg::ST_SLAVE: begin
        if (ram_ack) begin
          st_nxt.rd      = 1'b0;
          st_nxt.we_lo_n = 1'b1;
          st_nxt.we_hi_n = 1'b1;
          if (st_r.rd_xfer) begin
            st_nxt.bus_out = (st_r.mode == dp_steer_pkg::MODE_ODD) ?
                             {`LANE_OFF, ram_rdata[`WORD_W-1:`LANE_HI_LSB]} :
                             ram_rdata;
          end
          st_nxt.xack_n  = 1'b0;
          st_nxt.state   = dp_steer_pkg::ST_SLAVE_WAIT;
        end
      end
      dp_steer_pkg::ST_SLAVE_WAIT: begin
        // slave mode holds until the remote command is gone
        if (!st_r.req) begin
          st_nxt.xack_n = 1'b1;
          st_nxt.state  = dp_steer_pkg::ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = dp_steer_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r         <= '0;
      st_r.state   <= dp_steer_pkg::ST_IDLE;
      st_r.mode    <= dp_steer_pkg::MODE_NONE;
      st_r.s1      <= '1;
      st_r.s2      <= '1;
      st_r.s3      <= '1;
      st_r.we_lo_n <= 1'b1;
      st_r.we_hi_n <= 1'b1;
      st_r.xack_n  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // transceiver enables and outputs
  // ****************************************
  logic slave_act;
  logic lo_lane_on;
  logic hi_lane_on;

  assign remote_grant = (st_r.state == dp_steer_pkg::ST_SLAVE) ||
                        (st_r.state == dp_steer_pkg::ST_SLAVE_WAIT);
  assign local_grant  = (st_r.state == dp_steer_pkg::ST_LOCAL);
  assign slave_act    = remote_grant && (st_r.mode != dp_steer_pkg::MODE_NONE);
  assign word_lane_en_n = !(slave_act && (st_r.mode == dp_steer_pkg::MODE_WORD ||
                                          st_r.mode == dp_steer_pkg::MODE_EVEN));
  assign swap_lane_en_n = !(slave_act && st_r.mode == dp_steer_pkg::MODE_ODD);
  assign bus_transfer_direction = slave_act && st_r.rd_xfer;
  // drive only lanes whose transceiver is on and pointed outward
  assign lo_lane_on = bus_transfer_direction && !(word_lane_en_n && swap_lane_en_n);
  assign hi_lane_on = bus_transfer_direction && st_r.mode == dp_steer_pkg::MODE_WORD;
  assign bus_data_oe = {hi_lane_on ? `LANE_ON : `LANE_OFF, lo_lane_on ? `LANE_ON : `LANE_OFF};

  assign bus_data_out             = st_r.bus_out;
  assign bus_xack_n               = st_r.xack_n;
  assign remote_ram_request       = st_r.req;
  assign local_done               = st_r.done;
  assign local_rdata              = st_r.lrdata;
  assign ram_addr                 = st_r.addr;
  assign ram_wdata                = st_r.wdata;
  assign ram_read                 = st_r.rd;
  assign low_byte_write_strobe_n  = st_r.we_lo_n;
  assign high_byte_write_strobe_n = st_r.we_hi_n;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_off_no_drive;
    (word_lane_en_n && swap_lane_en_n) |-> (bus_data_oe == '0);
  endproperty
  a_off_no_drive: assert property (p_off_no_drive) else $error("oe while disabled");

  property p_dir_in;
    !bus_transfer_direction |-> (bus_data_oe == '0);
  endproperty
  a_dir_in: assert property (p_dir_in) else $error("drive while receiving");

  property p_idle_quiet;
    (st_r.state == dp_steer_pkg::ST_IDLE || local_grant) |->
      (word_lane_en_n && swap_lane_en_n);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("enable outside slave");

  property p_even_lane;
    (slave_act && st_r.mode == dp_steer_pkg::MODE_EVEN && st_r.rd_xfer) |->
      (!word_lane_en_n && swap_lane_en_n && bus_data_oe == {`LANE_OFF, `LANE_ON});
  endproperty
  a_even_lane: assert property (p_even_lane) else $error("even lanes wrong");

  property p_odd_lane;
    (slave_act && st_r.mode == dp_steer_pkg::MODE_ODD) |->
      (word_lane_en_n && !swap_lane_en_n);
  endproperty
  a_odd_lane: assert property (p_odd_lane) else $error("odd lanes wrong");

  property p_word_lane;
    (slave_act && st_r.mode == dp_steer_pkg::MODE_WORD && st_r.rd_xfer) |->
      (!word_lane_en_n && swap_lane_en_n && bus_data_oe == '1);
  endproperty
  a_word_lane: assert property (p_word_lane) else $error("word lanes wrong");

  property p_swap_read;
    (st_r.state == dp_steer_pkg::ST_SLAVE && ram_ack && st_r.rd_xfer &&
     st_r.mode == dp_steer_pkg::MODE_ODD) |=>
      (bus_data_out[`LANE_LO_MSB:0] == $past(ram_rdata[`WORD_W-1:`LANE_HI_LSB]) && !bus_xack_n);
  endproperty
  a_swap_read: assert property (p_swap_read) else $error("swap read byte wrong");

  property p_strobe;
    (!low_byte_write_strobe_n |-> !st_r.mode[0]) and
    (!high_byte_write_strobe_n |-> !st_r.mode[1]);
  endproperty
  a_strobe: assert property (p_strobe) else $error("write strobe mismatch");

  property p_local_first;
    (st_r.state == dp_steer_pkg::ST_IDLE && lq_valid && lq_mode != dp_steer_pkg::MODE_NONE)
      |=> local_grant;
  endproperty
  a_local_first: assert property (p_local_first) else $error("local not granted");

  property p_no_preempt;
    (remote_grant && remote_ram_request) |=> remote_grant;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("slave preempted");

  property p_excl;
    !(local_grant && remote_grant) && !(local_grant && !bus_xack_n);
  endproperty
  a_excl: assert property (p_excl) else $error("both sides granted");

  property p_unused;
    (remote_grant && st_r.mode == dp_steer_pkg::MODE_NONE) |->
      (!ram_read && low_byte_write_strobe_n && high_byte_write_strobe_n && bus_xack_n);
  endproperty
  a_unused: assert property (p_unused) else $error("unused mode accessed ram");

  c_local: cover property (local_grant ##[1:20] local_done);
  c_odd_read: cover property (slave_act && st_r.mode == dp_steer_pkg::MODE_ODD &&
                              st_r.rd_xfer ##[1:20] !bus_xack_n);
  c_word_write: cover property (slave_act && st_r.mode == dp_steer_pkg::MODE_WORD &&
                                !st_r.rd_xfer);
  c_slave_then_local: cover property (remote_grant && lq_valid ##[1:40] local_grant);

endmodule // dp_ram_steering

`default_nettype wire

// ===== shared/dp_steer_cfg.svh
`ifndef DP_STEER_CFG_SVH
`define DP_STEER_CFG_SVH

// ****************************************
// data path widths
// ****************************************
`define BYTE_W      8
`define WORD_W      16
`define ADDR_W      16
`define LANE_LO_MSB 7
`define LANE_HI_LSB 8
`define LANE_ON     8'hFF
`define LANE_OFF    8'h00

// ****************************************
// pin synchroniser vector layout
// ****************************************
`define SY_RD       0
`define SY_WR       1
`define SY_SEL      2
`define SY_A0       3
`define SY_BHE      4
`define SY_ADDR_LO  5
`define SY_ADDR_HI  19
`define SY_DATA_LO  20
`define SY_DATA_HI  35
`define SYNC_W      36

// ****************************************
// local request queue entry layout
// ****************************************
`define LQ_DATA_LO  0
`define LQ_DATA_HI  15
`define LQ_A0       16
`define LQ_ADDR_LO  17
`define LQ_ADDR_HI  31
`define LQ_BHE      32
`define LQ_WR       33
`define LQ_W        34
`define LQ_DEPTH    32

`endif

// ===== shared/dp_steer_pkg.sv
`include "dp_steer_cfg.svh"

package dp_steer_pkg;

  // ****************************************
  // arbiter states and lane modes
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE       = 2'b00,
    ST_LOCAL      = 2'b01,
    ST_SLAVE      = 2'b10,
    ST_SLAVE_WAIT = 2'b11
  } arb_state_e;

  // mode code is {byte_high_enable_n, address bit 0}
  typedef enum logic [1:0] {
    MODE_WORD = 2'b00,
    MODE_ODD  = 2'b01,
    MODE_EVEN = 2'b10,
    MODE_NONE = 2'b11
  } xfer_mode_e;

  typedef struct packed {
    arb_state_e              state;
    xfer_mode_e              mode;
    logic                    rd_xfer;
    logic                    req;
    logic [`SYNC_W-1:0]      s1;
    logic [`SYNC_W-1:0]      s2;
    logic [`SYNC_W-1:0]      s3;
    logic [`ADDR_W-1:1]      addr;
    logic [`WORD_W-1:0]      wdata;
    logic                    rd;
    logic                    we_lo_n;
    logic                    we_hi_n;
    logic [`WORD_W-1:0]      bus_out;
    logic [`WORD_W-1:0]      lrdata;
    logic                    xack_n;
    logic                    done;
  } steer_state_s;

  typedef struct packed {
    logic [4:0] wp;
    logic [4:0] rp;
    logic [5:0] cnt;
  } fifo_state_s;

endpackage

// ===== rtl/req_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "dp_steer_cfg.svh"

module req_fifo #(
  parameter int W     = `LQ_W,
  parameter int DEPTH = `LQ_DEPTH
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]              mem [DEPTH];
  dp_steer_pkg::fifo_state_s f_r;
  dp_steer_pkg::fifo_state_s f_nxt;
  logic                      push;
  logic                      pop;

  assign in_ready  = (f_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (f_r.cnt != '0);
  assign out_data  = mem[f_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    f_nxt    = f_r;
    f_nxt.wp = push ? f_r.wp + 1'b1 : f_r.wp;
    f_nxt.rp = pop ? f_r.rp + 1'b1 : f_r.rp;
    if (push && !pop) begin
      f_nxt.cnt = f_r.cnt + 1'b1;
    end else if (pop && !push) begin
      f_nxt.cnt = f_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      f_r <= '0;
    end else begin
      f_r <= f_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[f_r.wp] <= in_data;
    end
  end

endmodule // req_fifo

`default_nettype wire

// ===== sim/remote_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
`include "dp_steer_cfg.svh"

module remote_bus_master (
  input  wire logic               ref_clk,
  output logic                    bus_mem_rd_n,
  output logic                    bus_mem_wr_n,
  output logic                    board_select,
  output logic [`ADDR_W-1:1]      bus_addr,
  output logic                    buffered_address_bit0,
  output logic                    byte_high_enable_n,
  output logic [`WORD_W-1:0]      bus_data_in,
  input  wire logic [`WORD_W-1:0] bus_data_out,
  input  wire logic [`WORD_W-1:0] bus_data_oe,
  input  wire logic               bus_xack_n
);
  logic [`WORD_W-1:0] mdata;
  logic [`WORD_W-1:0] last;
  logic               mdrv;

  // ****************************************
  // wire level: undriven lanes toggle
  // ****************************************
  assign bus_data_in = (bus_data_oe & bus_data_out)
                     | (~bus_data_oe & (mdrv ? mdata : ~last));

  always @(posedge ref_clk) last <= bus_data_in;

  initial begin
    bus_mem_rd_n = 1'b1;
    bus_mem_wr_n = 1'b1;
    board_select = 1'b0;
    bus_addr = '0;
    buffered_address_bit0 = 1'b0;
    byte_high_enable_n = 1'b1;
    mdata = '0;
    mdrv = 1'b0;
    last = '0;
  end

  // ****************************************
  // one bus cycle, held until acknowledge
  // ****************************************
  task automatic xfer(input logic wr, input logic sel, input logic a0, input logic bhe_n,
                      input logic [`ADDR_W-1:1] a, input logic [`WORD_W-1:0] wd,
                      output logic [`WORD_W-1:0] rd, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    rd = '0;
    @(negedge ref_clk);
    bus_addr = a;
    buffered_address_bit0 = a0;
    byte_high_enable_n = bhe_n;
    board_select = sel;
    mdata = wd;
    mdrv = wr;
    bus_mem_wr_n = !wr;
    bus_mem_rd_n = wr;
    // no acknowledge: bus timeout ends the cycle
    while (n < 150 && !ok) begin
      @(posedge ref_clk);
      n++;
      if (bus_xack_n === 1'b0) begin
        ok = 1'b1;
        rd = bus_data_in;
      end
    end
    @(negedge ref_clk);
    bus_mem_rd_n = 1'b1;
    bus_mem_wr_n = 1'b1;
    mdrv = 1'b0;
    board_select = 1'b0;
    n = 0;
    while (n < 20 && bus_xack_n !== 1'b1) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(negedge ref_clk);
  endtask
endmodule // remote_bus_master

`default_nettype wire

// ===== sim/dp_ram_steering_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dp_steer_cfg.svh"

module dp_ram_steering_bench;
  logic               ref_clk, rst, local_req_valid, local_req_write, local_req_bhe_n;
  logic [`ADDR_W-1:0] local_req_addr;
  logic [`WORD_W-1:0] local_req_wdata, local_rdata, bus_data_in, bus_data_out, bus_data_oe;
  logic [`WORD_W-1:0] ram_wdata, ram_rdata, snap_oe;
  logic [`ADDR_W-1:1] bus_addr, ram_addr;
  logic               local_req_ready, local_done, bus_mem_rd_n, bus_mem_wr_n, board_select;
  logic               buffered_address_bit0, byte_high_enable_n, word_lane_en_n;
  logic               swap_lane_en_n, bus_transfer_direction, bus_xack_n, remote_ram_request;
  logic               local_grant, remote_grant, ram_read, ram_ack, en_seen, rr_seen;
  logic               low_byte_write_strobe_n, high_byte_write_strobe_n;
  logic [`WORD_W-1:0] mem [16];
  logic [2:0]         snap;
  int                 err_count, checked, lat, wcnt, acks, ndone, cyc, t_done, t_xack;

  dp_ram_steering dut (.*);
  remote_bus_master rm (.*);

  always #12.5 ref_clk = ~ref_clk;

  // ****************************************
  // ram controller model and monitors
  // ****************************************
  always @(posedge ref_clk) begin
    ram_ack <= 1'b0;
    if (!ram_ack && (ram_read || !low_byte_write_strobe_n || !high_byte_write_strobe_n)) begin
      wcnt <= wcnt + 1;
      if (wcnt >= lat) begin
        wcnt <= 0;
        ram_ack <= 1'b1;
        acks <= acks + 1;
        ram_rdata <= mem[ram_addr[4:1]];
        if (!low_byte_write_strobe_n) mem[ram_addr[4:1]][7:0] <= ram_wdata[7:0];
        if (!high_byte_write_strobe_n) mem[ram_addr[4:1]][15:8] <= ram_wdata[15:8];
      end
    end
    if (bus_xack_n === 1'b0) begin
      snap <= {word_lane_en_n, swap_lane_en_n, bus_transfer_direction};
      snap_oe <= bus_data_oe;
      if (t_xack == 0) t_xack <= cyc;
    end
    if (word_lane_en_n === 1'b0 || swap_lane_en_n === 1'b0) en_seen <= 1'b1;
    if (remote_ram_request === 1'b1) rr_seen <= 1'b1;
    if (local_done === 1'b1) begin
      ndone <= ndone + 1;
      t_done <= cyc;
    end
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      finish_test();
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic cmp_word(input string n, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  task automatic cmp_bit(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("[ERR] %s expected %b seen %b", n, e, g);
      err_count++;
    end
  endtask

  task automatic local_push(input logic wr, input logic [15:0] a, input logic bhe_n,
                            input logic [15:0] wd);
    int n;
    n = 0;
    @(negedge ref_clk);
    local_req_valid = 1'b1;
    local_req_write = wr;
    local_req_addr = a;
    local_req_bhe_n = bhe_n;
    local_req_wdata = wd;
    @(posedge ref_clk);
    while (local_req_ready !== 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    local_req_valid = 1'b0;
  endtask

  task automatic wait_done(input int target);
    int n;
    n = 0;
    while (ndone < target && n < 600) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_reset();
    cmp_word("idle outputs", 16'h0039, 16'({word_lane_en_n, swap_lane_en_n, bus_xack_n,
             local_grant, remote_grant, local_req_ready}));
    cmp_word("idle oe", 16'h0000, bus_data_oe);
    $display("test reset done");
  endtask

  task automatic test_remote_modes();
    logic [15:0] d, r, m, oe;
    logic [1:0]  c;
    logic        ok;
    m = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      c = 2'(k);
      d = 16'hA050 + 16'h0101 * 16'(k);
      oe = (c == 2'b00) ? 16'hFFFF : 16'h00FF;
      lat = k + 1;
      if (c != 2'b01) m[7:0] = d[7:0];
      if (c == 2'b00) m[15:8] = d[15:8];
      if (c == 2'b01) m[15:8] = d[7:0];
      rm.xfer(1'b1, 1'b1, c[0], c[1], 15'h0005, d, r, ok);
      cmp_bit("write ack", 1'b1, ok);
      cmp_word("write enables", 16'({c == 2'b01, c != 2'b01, 1'b0}), 16'(snap));
      cmp_word("write oe", 16'h0000, snap_oe);
      cmp_word("ram word", m, mem[5]);
      rm.xfer(1'b0, 1'b1, c[0], c[1], 15'h0005, 16'h0000, r, ok);
      cmp_word("read enables", 16'({c == 2'b01, c != 2'b01, 1'b1}), 16'(snap));
      cmp_word("read oe", oe, snap_oe);
      cmp_word("read lanes", (c == 2'b00) ? m : {8'h00, (c == 2'b01) ? m[15:8] : m[7:0]},
               r & oe);
    end
    rr_seen = 1'b0;
    rm.xfer(1'b1, 1'b0, 1'b0, 1'b0, 15'h0005, 16'hFFFF, r, ok);
    cmp_bit("unselected ack", 1'b0, ok);
    cmp_bit("unselected request", 1'b0, rr_seen);
    cmp_word("unselected ram", m, mem[5]);
    $display("test remote modes done");
  endtask

  task automatic test_local();
    int n0, a0;
    n0 = ndone;
    a0 = acks;
    lat = 2;
    en_seen = 1'b0;
    local_push(1'b1, 16'h0010, 1'b0, 16'h1357);
    local_push(1'b1, 16'h0010, 1'b1, 16'hFFAA);
    local_push(1'b1, 16'h0011, 1'b0, 16'h77FF);
    local_push(1'b1, 16'h0011, 1'b1, 16'h0000);
    local_push(1'b0, 16'h0010, 1'b0, 16'h0000);
    wait_done(n0 + 5);
    cmp_word("local ram word", 16'h77AA, mem[8]);
    cmp_word("local read", 16'h77AA, local_rdata);
    cmp_word("local ram cycles", 16'h0004, 16'(acks - a0));
    cmp_bit("local enables", 1'b0, en_seen);
    $display("test local done");
  endtask

  task automatic test_fill();
    logic [15:0] r;
    logic        ok;
    int          n, n0, a0;
    n = 0;
    n0 = ndone;
    a0 = acks;
    en_seen = 1'b0;
    fork
      rm.xfer(1'b1, 1'b1, 1'b1, 1'b1, 15'h0005, 16'h0000, r, ok);
      begin
        while (remote_grant !== 1'b1 && n < 50) begin
          @(negedge ref_clk);
          n++;
        end
        for (int i = 0; i < 32; i++) local_push(1'b1, 16'h0012, 1'b0, 16'h0100 + 16'(i));
        cmp_bit("queue full", 1'b0, local_req_ready);
        cmp_word("slave ram cycles", 16'h0000, 16'(acks - a0));
        cmp_bit("local held", 1'b0, local_grant);
      end
    join
    cmp_bit("unused ack", 1'b0, ok);
    cmp_bit("unused enables", 1'b0, en_seen);
    lat = 3;
    wait_done(n0 + 32);
    cmp_word("drained count", 16'h0020, 16'(ndone - n0));
    cmp_word("last write", 16'h011F, mem[9]);
    cmp_bit("queue empty", 1'b1, local_req_ready);
    $display("test fill done");
  endtask

  task automatic test_tie();
    logic [15:0] r;
    logic        ok;
    lat = 8;
    t_xack = 0;
    fork
      begin
        // local push lands as the remote command clears the synchroniser
        repeat (2) @(negedge ref_clk);
        local_push(1'b0, 16'h0012, 1'b0, 16'h0000);
      end
      rm.xfer(1'b0, 1'b1, 1'b0, 1'b0, 15'h0005, 16'h0000, r, ok);
    join
    cmp_bit("remote served", 1'b1, ok);
    cmp_bit("local first", 1'b1, t_xack != 0 && t_done < t_xack);
    cmp_word("tie read", mem[5], r);
    $display("test tie done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    local_req_valid = 1'b0;
    local_req_write = 1'b0;
    local_req_addr = '0;
    local_req_bhe_n = 1'b1;
    local_req_wdata = '0;
    ram_ack = 1'b0;
    ram_rdata = '0;
    {err_count, checked, wcnt, acks, ndone, cyc, t_done, t_xack} = '0;
    lat = 1;
    en_seen = 1'b0;
    rr_seen = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = '0;
    repeat (20) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge ref_clk);
    test_reset();
    test_remote_modes();
    test_local();
    test_fill();
    test_tie();
    finish_test();
  end
endmodule // dp_ram_steering_bench

`default_nettype wire
